// ---- wdrst_pkg.sv ----
// Purpose: shared constants for the watchdog and reset-source logic
// Assumes: one 250 MHz system clock; register port with 2-bit address
// Notes:   all offsets, field positions, reset values and timings live here
package wdrst_pkg;

  // clock and derived rates
  localparam int unsigned CLK_HZ        = 250_000_000;
  localparam int unsigned WDT_OSC_HZ    = 1_000_000;
  localparam int unsigned WDT_OSC_DIV   = CLK_HZ / WDT_OSC_HZ;

  // watchdog base period in oscillator ticks, doubled per prescale step
  localparam int unsigned WDT_BASE_TICKS = 16_384;
  localparam int unsigned WDT_PSEL_MAX   = 7;
  localparam int unsigned WDT_CNT_W      = 22;

  // change-enable window length in system clock cycles
  localparam int unsigned CE_WINDOW     = 4;
  localparam logic [2:0]  CE_WINDOW_C   = 3'h4;

  // brown-out filter time, least time, rounded up to whole cycles
  localparam int unsigned BOD_FILTER_NS = 2_000;
  localparam int unsigned CLK_PERIOD_PS = 4_000;
  localparam int unsigned BOD_FILTER_CYC =
    (BOD_FILTER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // reset delay period in microseconds and its cycle count
  localparam int unsigned RESET_DELAY_US  = 64;
  localparam int unsigned RESET_DELAY_CYC = RESET_DELAY_US * (CLK_HZ / 1_000_000);

  // register map
  localparam int unsigned REG_ADDR_W      = 2;
  localparam logic [1:0]  OFS_RESET_FLAGS = 2'h0;
  localparam logic [1:0]  OFS_WDT_CTRL    = 2'h1;

  // reset_cause_flags fields
  localparam int unsigned FLAG_POWERON  = 0;
  localparam int unsigned FLAG_EXTERNAL = 1;
  localparam int unsigned FLAG_BROWNOUT = 2;
  localparam int unsigned FLAG_WATCHDOG = 3;
  localparam logic [3:0]  FLAGS_POR_VAL = 4'h1;

  // watchdog_control fields
  localparam int unsigned CTRL_PSEL_LSB = 0;
  localparam int unsigned CTRL_ENABLE   = 3;
  localparam int unsigned CTRL_CHANGE   = 4;
  localparam logic [2:0]  PSEL_RST_VAL  = 3'h0;

endpackage : wdrst_pkg

// ---- wdrst_filter.sv ----
// Purpose: persistence filter, output rises after input held FILTER cycles
// Assumes: input synchronous to clock
// Notes:   output falls in the cycle after the input falls
module wdrst_filter
  import wdrst_pkg::*;
#(
  parameter int unsigned FILTER = BOD_FILTER_CYC
) (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic level_in,
  output logic      level_out
);

  if (FILTER < 1 || FILTER > 65535) begin : g_chk
    $error("wdrst_filter: FILTER out of range");
  end

  typedef struct packed {
    logic [15:0] cnt;
    logic        out;
  } wdrst_filt_t;

  wdrst_filt_t st_r;
  wdrst_filt_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (!level_in) begin
      st_nxt.cnt = 16'h0000;
      st_nxt.out = 1'b0;
    end else if (st_r.cnt == 16'(FILTER - 1)) begin
      st_nxt.out = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + 16'h0001;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign level_out = st_r.out;

endmodule // wdrst_filter

// ---- wdrst_delay.sv ----
// Purpose: reset delay counter stretching the internal reset
// Assumes: hold is a level; counting starts the cycle hold falls
// Notes:   busy stays high while hold is high and for DELAY cycles after
module wdrst_delay #(
  parameter int unsigned DELAY = 16_000
) (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic hold,
  output logic      busy
);

  if (DELAY < 1 || DELAY > 16777215) begin : g_chk
    $error("wdrst_delay: DELAY out of range");
  end

  typedef struct packed {
    logic [23:0] cnt;
  } wdrst_dly_t;

  wdrst_dly_t st_r;
  wdrst_dly_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (hold) begin
      st_nxt.cnt = 24'(DELAY);
    end else if (st_r.cnt != 24'h000000) begin
      st_nxt.cnt = st_r.cnt - 24'h000001;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_r.cnt <= 24'(DELAY);
    end else begin
      st_r <= st_nxt;
    end
  end

  assign busy = hold | (st_r.cnt != 24'h000000);

endmodule // wdrst_delay

// ---- wdrst_top.sv ----
// Purpose: watchdog timer with timed change sequences and reset-source capture
// Assumes: all inputs synchronous to clock; rst is the block's own power-up reset
// Notes:   the watchdog oscillator is modelled as a 1 MHz enable from a divider
//          registers: reset_cause_flags at 0, watchdog_control at 1

// Contract
// - brown-out reset asserts at once when enabled
// - hold reset for delay after supply recovers
// - ignore supply dips shorter than filter time
// - watchdog timeout gives one-cycle reset pulse
// - delay starts on falling edge of pulse
// - bandgap on for brown-out, comparator or converter
// - watchdog runs from separate 1 MHz oscillator
// - restart, disable or chip reset clear count
// - timeout without restart resets the device
// - level one: starts disabled, single write enables
// - level two: always enabled, enable reads one
// - level two: sequence changes prescaler, enable ignored
// - change-enable self-clears four cycles after set
// - enable clears only while change-enable set
// - enable one turns on, permitted zero off
// - control: change bit4, enable bit3, 7:5 zero
// - flags 3..1 latch sources, cleared by por/write
// - flag 0 set by power-on, cleared by write
// - flag register bits 7:4 read zero
// - prescaler selects 16K to 2048K oscillator ticks
module wdrst_top
  import wdrst_pkg::*;
#(
  parameter int unsigned BASE_TICKS   = WDT_BASE_TICKS,
  parameter int unsigned OSC_DIV      = WDT_OSC_DIV,
  parameter int unsigned DELAY_CYCLES = RESET_DELAY_CYC,
  parameter int unsigned FILTER_CYC   = BOD_FILTER_CYC
) (
  input  wire logic                  clock,
  input  wire logic                  rst,
  input  wire logic                  poweron_reset,
  input  wire logic                  external_reset_n,
  input  wire logic                  supply_low,
  input  wire logic                  brownout_enable_fuse,
  input  wire logic                  brownout_level_fuse,
  input  wire logic                  watchdog_always_on_fuse,
  input  wire logic                  comparator_bandgap_select,
  input  wire logic                  adc_enable,
  input  wire logic                  watchdog_restart_instruction,
  input  wire logic [REG_ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]            reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [7:0]            reg_rdata,
  output logic                       core_reset,
  output logic                       brownout_reset,
  output logic                       watchdog_reset_pulse,
  output logic                       bandgap_enable,
  output logic                       brownout_level_select,
  output logic                       watchdog_running
);

  // elaboration checks
  if (BASE_TICKS < 2 || (64'(BASE_TICKS) << WDT_PSEL_MAX) > (64'h1 << WDT_CNT_W)) begin : g_chk_b
    $error("wdrst_top: BASE_TICKS does not fit the watchdog counter");
  end
  if (OSC_DIV < 1 || OSC_DIV > 65535) begin : g_chk_d
    $error("wdrst_top: OSC_DIV out of range");
  end

  typedef struct packed {
    logic [15:0]          div_cnt;
    logic                 tick;
    logic [WDT_CNT_W-1:0] wdt_cnt;
    logic                 wdt_pulse;
    logic                 en;
    logic                 ce;
    logic [2:0]           ce_cnt;
    logic [2:0]           psel;
    logic [3:0]           flags;
    logic [7:0]           rdata;
  } wdrst_state_t;

  wdrst_state_t st_r;
  wdrst_state_t st_nxt;

  logic                 bod_filtered;
  logic                 bod_active;
  logic                 ext_active;
  logic                 src_hold;
  logic                 delay_busy;
  logic                 chip_reset;
  logic                 level_two;
  logic                 en_view;
  logic                 run;
  logic [WDT_CNT_W-1:0] limit;
  logic [7:0]           ctrl_view;
  logic                 wr_ctrl;
  logic                 wr_flags;
  logic                 w_ce;
  logic                 w_en;
  logic [2:0]           w_psel;

  // brown-out path: dips shorter than the filter time never get through
  wdrst_filter #(
    .FILTER (FILTER_CYC)
  ) u_bod_filter (
    .clock     (clock),
    .rst       (rst),
    .level_in  (supply_low & brownout_enable_fuse),
    .level_out (bod_filtered)
  );

  assign bod_active = bod_filtered & brownout_enable_fuse;
  assign ext_active = ~external_reset_n;

  // any live source, or the watchdog pulse, holds the delay counter loaded
  assign src_hold = poweron_reset | ext_active | bod_active | st_r.wdt_pulse;

  wdrst_delay #(
    .DELAY (DELAY_CYCLES)
  ) u_delay (
    .clock (clock),
    .rst   (rst),
    .hold  (src_hold),
    .busy  (delay_busy)
  );

  assign chip_reset = delay_busy;

  assign level_two = watchdog_always_on_fuse;
  assign en_view   = st_r.en | level_two;
  assign run       = en_view & ~chip_reset;

  // timeout length in oscillator ticks, doubling per prescale code
  assign limit = WDT_CNT_W'(BASE_TICKS) << st_r.psel;

  // reserved high bits read zero
  assign ctrl_view = {3'h0, st_r.ce, en_view, st_r.psel};

  assign wr_ctrl  = reg_wr & (reg_addr == OFS_WDT_CTRL);
  assign wr_flags = reg_wr & (reg_addr == OFS_RESET_FLAGS);
  assign w_ce     = reg_wdata[CTRL_CHANGE];
  assign w_en     = reg_wdata[CTRL_ENABLE];
  assign w_psel   = reg_wdata[CTRL_PSEL_LSB +: 3];

  always_comb begin
    st_nxt = st_r;

    // oscillator tick divider, free running and independent of the core
    st_nxt.tick = 1'b0;
    if (st_r.div_cnt == 16'(OSC_DIV - 1)) begin
      st_nxt.div_cnt = 16'h0000;
      st_nxt.tick    = 1'b1;
    end else begin
      st_nxt.div_cnt = st_r.div_cnt + 16'h0001;
    end

    // watchdog counter and expiry
    st_nxt.wdt_pulse = 1'b0;
    if (!run || watchdog_restart_instruction) begin
      st_nxt.wdt_cnt = '0;
    end else if (st_r.tick) begin
      if (st_r.wdt_cnt == limit - WDT_CNT_W'(1)) begin
        st_nxt.wdt_cnt   = '0;
        st_nxt.wdt_pulse = 1'b1;
      end else begin
        st_nxt.wdt_cnt = st_r.wdt_cnt + WDT_CNT_W'(1);
      end
    end

    // change-enable window closes on its own after four cycles
    if (st_r.ce) begin
      if (st_r.ce_cnt == 3'h1) begin
        st_nxt.ce     = 1'b0;
        st_nxt.ce_cnt = 3'h0;
      end else begin
        st_nxt.ce_cnt = st_r.ce_cnt - 3'h1;
      end
    end

    // control register writes
    if (wr_ctrl) begin
      if (w_ce) begin
        // first step: enable written one beside change-enable opens the window
        if (w_en) begin
          st_nxt.en     = 1'b1;
          st_nxt.ce     = 1'b1;
          st_nxt.ce_cnt = CE_WINDOW_C;
        end
      end else if (st_r.ce) begin
        // second step inside the window
        st_nxt.psel   = w_psel;
        st_nxt.ce     = 1'b0;
        st_nxt.ce_cnt = 3'h0;
        if (!level_two) begin
          st_nxt.en = w_en;
        end
      end else if (w_en) begin
        st_nxt.en = 1'b1;
      end
    end

    // chip reset returns control to its initial state
    if (chip_reset) begin
      st_nxt.en     = 1'b0;
      st_nxt.ce     = 1'b0;
      st_nxt.ce_cnt = 3'h0;
      st_nxt.psel   = PSEL_RST_VAL;
    end

    // reset flags: write zero clears, write one keeps, a source set wins
    if (wr_flags) begin
      st_nxt.flags = st_r.flags & reg_wdata[3:0];
    end
    if (st_r.wdt_pulse) begin
      st_nxt.flags[FLAG_WATCHDOG] = 1'b1;
    end
    if (bod_active) begin
      st_nxt.flags[FLAG_BROWNOUT] = 1'b1;
    end
    if (ext_active) begin
      st_nxt.flags[FLAG_EXTERNAL] = 1'b1;
    end
    if (poweron_reset) begin
      st_nxt.flags = FLAGS_POR_VAL;
    end

    // read data, valid in the cycle after the strobe only
    st_nxt.rdata = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        OFS_RESET_FLAGS: st_nxt.rdata = {4'h0, st_r.flags};
        OFS_WDT_CTRL:    st_nxt.rdata = ctrl_view;
        default:         st_nxt.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_r.div_cnt   <= 16'h0000;
      st_r.tick      <= 1'b0;
      st_r.wdt_cnt   <= '0;
      st_r.wdt_pulse <= 1'b0;
      st_r.en        <= 1'b0;
      st_r.ce        <= 1'b0;
      st_r.ce_cnt    <= 3'h0;
      st_r.psel      <= PSEL_RST_VAL;
      st_r.flags     <= FLAGS_POR_VAL;
      st_r.rdata     <= 8'h00;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata             = st_r.rdata;
  assign core_reset            = chip_reset;
  assign brownout_reset        = bod_active;
  assign watchdog_reset_pulse  = st_r.wdt_pulse;
  assign bandgap_enable        = brownout_enable_fuse | comparator_bandgap_select
                                 | adc_enable;
  assign brownout_level_select = brownout_level_fuse;
  assign watchdog_running      = run;

endmodule // wdrst_top

// ---- wdrst_properties.sv ----
// Purpose: port checks for the watchdog and reset logic
// Assumes: one clock domain, bound onto wdrst_top
// Notes:   delay checks assume a reset delay of seven cycles or more
module wdrst_properties
  import wdrst_pkg::*;
(
  input wire logic                  clock,
  input wire logic                  rst,
  input wire logic                  supply_low,
  input wire logic                  brownout_enable_fuse,
  input wire logic                  watchdog_always_on_fuse,
  input wire logic                  comparator_bandgap_select,
  input wire logic                  adc_enable,
  input wire logic [REG_ADDR_W-1:0] reg_addr,
  input wire logic                  reg_rd,
  input wire logic [7:0]            reg_rdata,
  input wire logic                  core_reset,
  input wire logic                  brownout_reset,
  input wire logic                  watchdog_reset_pulse,
  input wire logic                  bandgap_enable,
  input wire logic                  watchdog_running
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  chk_bandgap_sources: assert property (
    bandgap_enable == (brownout_enable_fuse | comparator_bandgap_select | adc_enable))
    else $error("bandgap enable differs from its sources");
  chk_bod_immediate: assert property (brownout_reset |-> core_reset)
    else $error("brown-out without core reset");
  chk_bod_filter: assert property ($rose(brownout_reset) |->
    $past(supply_low, 1) && $past(supply_low, 2) && $past(brownout_enable_fuse))
    else $error("brown-out before the filter time");
  chk_pulse_single: assert property (watchdog_reset_pulse |=> !watchdog_reset_pulse)
    else $error("watchdog pulse longer than one cycle");
  chk_pulse_resets: assert property (
    watchdog_reset_pulse |-> core_reset && !watchdog_running)
    else $error("watchdog pulse without core reset");
  chk_wdt_delay: assert property ($fell(watchdog_reset_pulse) |-> core_reset[*7])
    else $error("reset delay cut short after watchdog pulse");
  chk_bod_release: assert property ($fell(brownout_reset) |-> core_reset[*7])
    else $error("reset delay cut short after brown-out");
  chk_level_two_on: assert property (
    watchdog_always_on_fuse && !core_reset |-> watchdog_running)
    else $error("watchdog stopped at level two");
  chk_reserved_zero: assert property (reg_rdata[7:5] == 3'h0)
    else $error("reserved control bits read nonzero");
  chk_flag_upper: assert property (
    $past(reg_rd) && $past(reg_addr) == OFS_RESET_FLAGS |-> reg_rdata[7:4] == 4'h0)
    else $error("reserved flag bits read nonzero");
endmodule // wdrst_properties

bind wdrst_top wdrst_properties wdrst_properties_inst (
  .clock, .rst, .supply_low, .brownout_enable_fuse, .watchdog_always_on_fuse,
  .comparator_bandgap_select, .adc_enable, .reg_addr, .reg_rd, .reg_rdata, .core_reset,
  .brownout_reset, .watchdog_reset_pulse, .bandgap_enable, .watchdog_running);

// ---- tb_wdrst_top.sv ----
// Purpose: self-checking bench for the watchdog and reset logic
// Assumes: small parameters keep every timeout short
// Notes:   restart pulses run in the background while kick is high
module tb_wdrst_top
  import wdrst_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, rst, poweron_reset, external_reset_n, supply_low, brownout_enable_fuse;
  logic brownout_level_fuse, watchdog_always_on_fuse, comparator_bandgap_select, adc_enable;
  logic watchdog_restart_instruction, reg_wr, reg_rd, core_reset, brownout_reset, kick;
  logic watchdog_reset_pulse, bandgap_enable, brownout_level_select, watchdog_running;
  logic [REG_ADDR_W-1:0] reg_addr;
  logic [7:0]            reg_wdata, reg_rdata;
  int                    err_count, n_compared, cycles, n;

  wdrst_top #(.BASE_TICKS(4), .OSC_DIV(2), .DELAY_CYCLES(8), .FILTER_CYC(3)) wdrst_top_inst (
    .clock, .rst, .poweron_reset, .external_reset_n, .supply_low, .brownout_enable_fuse,
    .brownout_level_fuse, .watchdog_always_on_fuse, .comparator_bandgap_select, .adc_enable,
    .watchdog_restart_instruction, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .core_reset, .brownout_reset, .watchdog_reset_pulse, .bandgap_enable,
    .brownout_level_select, .watchdog_running);

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  always @(posedge clock) begin
    watchdog_restart_instruction <= kick && !watchdog_restart_instruction;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count = err_count + 1;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
  endtask

  task automatic rd(input logic [1:0] a, input logic [7:0] exp, input string nm);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    cmp(nm, exp, reg_rdata);
    @(posedge clock);
  endtask

  // pulse high picks the watchdog pulse, low picks core reset released
  task automatic wait_for(input logic pulse, input int lim);
    n = 0;
    @(negedge clock);
    while (n < lim && (pulse ? watchdog_reset_pulse !== 1'b1 : core_reset !== 1'b0)) begin
      @(negedge clock);
      n++;
    end
    cmp("wait bound", 8'h01, 8'(n < lim));
    @(posedge clock);
  endtask

  task automatic idle(input int k);
    repeat (k) @(posedge clock);
    @(negedge clock);
  endtask

  initial begin
    {rst, poweron_reset, supply_low, brownout_enable_fuse, brownout_level_fuse} = 5'h10;
    {watchdog_always_on_fuse, comparator_bandgap_select, adc_enable, kick} = 4'h0;
    {external_reset_n, reg_wr, reg_rd} = 3'h4;
    reg_addr = 2'h0;
    reg_wdata = 8'h00;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    wait_for(1'b0, 40);
    rd(2'h0, 8'h01, "flags after reset");
    rd(2'h1, 8'h00, "control after reset");
    rd(2'h2, 8'h00, "unmapped read");
    wr(2'h0, 8'hff);
    rd(2'h0, 8'h01, "flags kept by ones");
    wr(2'h0, 8'h00);
    rd(2'h0, 8'h00, "flags cleared");
    kick <= 1'b1;
    wr(2'h1, 8'h08);
    rd(2'h1, 8'h08, "single write enables");
    idle(0);
    cmp("running when enabled", 8'h01, 8'(watchdog_running));
    @(posedge clock);
    wr(2'h1, 8'h00);
    rd(2'h1, 8'h08, "enable kept");
    wr(2'h1, 8'hf8);
    rd(2'h1, 8'h18, "change window open");
    repeat (4) @(posedge clock);
    rd(2'h1, 8'h08, "change window closed");
    wr(2'h1, 8'h0d);
    rd(2'h1, 8'h08, "prescale without change");
    wr(2'h1, 8'h18);
    wr(2'h1, 8'h0b);
    rd(2'h1, 8'h0b, "prescale changed");
    wr(2'h1, 8'h18);
    wr(2'h1, 8'h00);
    rd(2'h1, 8'h00, "disabled");
    kick <= 1'b0;
    idle(40);
    cmp("running after disable", 8'h00, 8'(watchdog_running));
    @(posedge clock);
    $display("control test done");
    for (int p = 0; p < 3; p++) begin
      kick <= 1'b1;
      wr(2'h1, 8'h18);
      wr(2'h1, 8'h08 | 8'(p));
      kick <= 1'b0;
      wait_for(1'b1, 100);
      cmp("timeout length", 8'h01, 8'(n > (8 << p) - 4 && n < (8 << p) + 5));
      wait_for(1'b0, 40);
      rd(2'h0, 8'h08, "watchdog flag");
      wr(2'h0, 8'h00);
    end
    watchdog_always_on_fuse <= 1'b1;
    kick <= 1'b1;
    rd(2'h1, 8'h08, "level two enable");
    wr(2'h1, 8'h18);
    wr(2'h1, 8'h02);
    rd(2'h1, 8'h0a, "level two prescale");
    kick <= 1'b0;
    wait_for(1'b1, 100);
    watchdog_always_on_fuse <= 1'b0;
    wait_for(1'b0, 40);
    wr(2'h0, 8'h00);
    $display("timeout test done");
    brownout_enable_fuse <= 1'b1;
    supply_low <= 1'b1;
    repeat (2) @(posedge clock);
    supply_low <= 1'b0;
    idle(4);
    cmp("short dip", 8'h00, 8'(brownout_reset));
    @(posedge clock);
    supply_low <= 1'b1;
    idle(6);
    cmp("brown-out reset", 8'h01, 8'(brownout_reset & core_reset));
    @(posedge clock);
    supply_low <= 1'b0;
    wait_for(1'b0, 40);
    rd(2'h0, 8'h04, "brown-out flag");
    external_reset_n <= 1'b0;
    repeat (2) @(posedge clock);
    external_reset_n <= 1'b1;
    wait_for(1'b0, 40);
    rd(2'h0, 8'h06, "external flag");
    poweron_reset <= 1'b1;
    repeat (2) @(posedge clock);
    poweron_reset <= 1'b0;
    wait_for(1'b0, 40);
    rd(2'h0, 8'h01, "power-on flags");
    $display("reset source test done");
    for (int i = 0; i < 8; i++) begin
      {brownout_enable_fuse, comparator_bandgap_select, adc_enable} <= 3'(i);
      brownout_level_fuse <= i[1];
      idle(1);
      cmp("bandgap", 8'(i != 0), 8'(bandgap_enable));
      cmp("level select", 8'(i[1]), 8'(brownout_level_select));
      @(posedge clock);
    end
    $display("bandgap test done");
    print_verdict();
  end
endmodule // tb_wdrst_top
